// ==== eps_core.sv ====
/*
 * Write enable latch, status byte, block and hardware write protection and
 * write cycle timing of a serial EEPROM. Serial clock logic sits in eps_link,
 * nonvolatile bits in eps_nv_cells. Assumes the array sequencer outside uses
 * the start pulse and address; array data is not handled here.
 */
// Functional notes
// - No write starts unless latch set
// - Latch set and clear commands drive latch
// - Latch cleared on reset, clear, completed writes
// - Status read answers even while busy
// - Status byte bit layout fixed
// - Busy flag shows write cycle, read only
// - Latch flag mirrors latch, not writable
// - Latch commands work despite hardware protection
// - Block protect bits nonvolatile, status write only
// - Block protect codes map to address ranges
// - Protect enable bit nonvolatile, gates pin
// - Hardware protect is pin low and enable
// - Hardware protect blocks only status writes
// - Protection matrix for array and status
// - Write starts only on correctly timed deselect
// - Accesses other than status read ignored during write cycle
// - Power-on standby, latch clear, output released
// - Command code values
// - Bits shifted most significant first
// - Started write finishes despite pin change
`timescale 1ns/1ps
`default_nettype none

module eps_core
    import eps_pkg::*;
#(
    parameter int unsigned WRITE_CYCLE_COUNT = eps_pkg::WRITE_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_nv_clr_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    output logic o_busy,
    output logic o_write_latch,
    output logic o_array_write_start,
    output logic [10:0] o_array_addr
);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic tg_s1;
        logic tg_s2;
        logic tg_d;
        logic wp_s1;
        logic wp_s2;
        logic [2:0] bitcnt;
        logic [2:0] bytecnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic [7:0] first_data;
        logic [10:0] addr;
        logic write_latch_flag;
        eps_cycle_type cycle;
        logic [TIMER_W-1:0] timer;
        logic array_start;
        logic nv_we;
    } eps_core_type;

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WRITE_CYCLE_COUNT - 1);

    eps_core_type core_reg, core_next;
    eps_link_if lnk();
    logic hwpe;
    logic [1:0] bp;
    logic hw_protect;

    eps_link u_link (
        .i_sck(i_sck),
        .i_rst_n(i_rst_n),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .lnk(lnk)
    );

    eps_nv_cells u_nv (
        .i_clk(i_clk),
        .i_nv_clr_n(i_nv_clr_n),
        .i_we(core_reg.nv_we),
        .i_wdata({core_reg.first_data[SR_HWPE_POS],
                  core_reg.first_data[SR_BP_HI_POS],
                  core_reg.first_data[SR_BP_LO_POS]}),
        .o_hw_protect_enable(hwpe),
        .o_block_protect(bp)
    );

    assign hw_protect = ~core_reg.wp_s2 & hwpe;

    always_comb begin
        logic [2:0] bc;
        logic [2:0] byc;
        logic [7:0] b;
        logic [7:0] opc;
        logic idle;
        bc = core_reg.bitcnt;
        byc = core_reg.bytecnt;
        b = core_reg.shreg;
        opc = core_reg.opcode;
        idle = (core_reg.cycle == EPS_IDLE);
        core_next = core_reg;
        core_next.array_start = 1'b0;
        core_next.nv_we = 1'b0;
        core_next.cs_s1 = i_cs_n;
        core_next.cs_s2 = core_reg.cs_s1;
        core_next.cs_d = core_reg.cs_s2;
        core_next.tg_s1 = lnk.bit_tgl;
        core_next.tg_s2 = core_reg.tg_s1;
        core_next.tg_d = core_reg.tg_s2;
        core_next.wp_s1 = i_wp_n;
        core_next.wp_s2 = core_reg.wp_s1;

        // Bit arrives: assemble bytes
        if (core_reg.tg_s2 != core_reg.tg_d) begin
            b = {core_reg.shreg[6:0], lnk.bit_val};
            if (bc == 3'h7) begin
                case (byc)
                    3'h0: opc = b;
                    // Frames during a write cycle must not disturb its data
                    3'h1: begin
                        if (idle) begin
                            core_next.first_data = b;
                            core_next.addr[10:8] = b[2:0];
                        end
                    end
                    3'h2: begin
                        if (idle) begin
                            core_next.addr[7:0] = b;
                        end
                    end
                    default: begin
                    end
                endcase
                if (byc != LEN_ARRAY_WRITE_MIN) begin
                    byc = byc + 3'h1;
                end
            end
            bc = bc + 3'h1;
        end

        // Deselect: act only on whole bytes of the right count
        if (core_reg.cs_s2 && !core_reg.cs_d) begin
            if (bc == 3'h0 && idle) begin
                case (opc)
                    OPC_LATCH_SET: begin
                        if (byc == LEN_LATCH_CMD) begin
                            core_next.write_latch_flag = 1'b1;
                        end
                    end
                    OPC_LATCH_CLEAR: begin
                        if (byc == LEN_LATCH_CMD) begin
                            core_next.write_latch_flag = 1'b0;
                        end
                    end
                    OPC_STATUS_WRITE: begin
                        if (byc == LEN_STATUS_WRITE && core_reg.write_latch_flag && !hw_protect) begin
                            core_next.cycle = EPS_STATUS_PROG;
                            core_next.timer = '0;
                        end
                    end
                    OPC_ARRAY_WRITE: begin
                        if (byc == LEN_ARRAY_WRITE_MIN && core_reg.write_latch_flag
                            && !eps_is_protected(core_reg.addr, bp)) begin
                            core_next.cycle = EPS_ARRAY_PROG;
                            core_next.timer = '0;
                            core_next.array_start = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            bc = 3'h0;
            byc = 3'h0;
        end

        // Self-timed cycle; pin changes no longer matter
        if (!idle) begin
            if (core_reg.timer == TIMER_LAST) begin
                core_next.cycle = EPS_IDLE;
                core_next.write_latch_flag = 1'b0;
                core_next.nv_we = (core_reg.cycle == EPS_STATUS_PROG);
            end else begin
                core_next.timer = core_reg.timer + TIMER_W'(1);
            end
        end

        core_next.bitcnt = bc;
        core_next.bytecnt = byc;
        core_next.shreg = b;
        core_next.opcode = opc;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_reg <= '0;
            core_reg.cs_s1 <= 1'b1;
            core_reg.cs_s2 <= 1'b1;
            core_reg.cs_d <= 1'b1;
            core_reg.wp_s1 <= 1'b1;
            core_reg.wp_s2 <= 1'b1;
            core_reg.write_latch_flag <= 1'b0;
            core_reg.cycle <= EPS_IDLE;
        end else begin
            core_reg <= core_next;
        end
    end

    // Status byte; unused bits zero, busy and latch not writable
    always_comb begin
        lnk.status = STATUS_RESET;
        lnk.status[SR_HWPE_POS] = hwpe;
        lnk.status[SR_BP_HI_POS] = bp[1];
        lnk.status[SR_BP_LO_POS] = bp[0];
        lnk.status[SR_LATCH_POS] = core_reg.write_latch_flag;
        lnk.status[SR_BUSY_POS] = (core_reg.cycle != EPS_IDLE);
    end

    assign o_busy = (core_reg.cycle != EPS_IDLE);
    assign o_write_latch = core_reg.write_latch_flag;
    assign o_array_write_start = core_reg.array_start;
    assign o_array_addr = core_reg.addr;

endmodule

`default_nettype wire

// ==== eps_core_assertions.sv ====
/*
 * Port checker for eps_core: write cycle, latch and output enable timing.
 * Assumes binding from the testbench top and one core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module eps_core_chk #(
    parameter int unsigned WRITE_CYCLE_COUNT = 50
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic o_so_oe,
    input wire logic o_busy,
    input wire logic o_write_latch,
    input wire logic o_array_write_start
);
    logic [31:0] busy_cnt_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt_reg <= '0;
        end else begin
            busy_cnt_reg <= o_busy ? busy_cnt_reg + 32'h0000_0001 : '0;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_start_busy;
        o_array_write_start |-> o_busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("array write start without busy");
    property p_rise_latch;
        $rose(o_busy) |-> o_write_latch;
    endproperty
    a_rise_latch: assert property (p_rise_latch)
        else $error("write cycle began with latch clear");
    property p_fall_clear;
        $fell(o_busy) |-> !o_write_latch && busy_cnt_reg == WRITE_CYCLE_COUNT;
    endproperty
    a_fall_clear: assert property (p_fall_clear)
        else $error("write cycle length or latch clear wrong");
    property p_cs_seen;
        $rose(o_busy) |-> $past(i_cs_n, 1) && $past(i_cs_n, 2);
    endproperty
    a_cs_seen: assert property (p_cs_seen)
        else $error("write cycle began while selected");
    property p_one_start;
        o_array_write_start |=> !o_array_write_start [*8];
    endproperty
    a_one_start: assert property (p_one_start)
        else $error("array write start repeated");
    property p_busy_latch;
        o_busy |-> $stable(o_write_latch);
    endproperty
    a_busy_latch: assert property (p_busy_latch)
        else $error("latch changed during write cycle");
    property p_latch_rise;
        $rose(o_write_latch) |-> !o_busy && $past(i_cs_n, 2);
    endproperty
    a_latch_rise: assert property (p_latch_rise)
        else $error("latch set outside a deselect");
    property p_latch_fall;
        $fell(o_write_latch) |-> $past(i_cs_n) || $fell(o_busy);
    endproperty
    a_latch_fall: assert property (p_latch_fall)
        else $error("latch cleared without cause");
    property p_oe_cs;
        i_cs_n |-> !o_so_oe;
    endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("output driven while deselected");

    c_busy: cover property ($rose(o_busy));
    c_start: cover property (o_array_write_start);
    c_read: cover property ($rose(o_so_oe));
endmodule

`default_nettype wire

// ==== eps_core_tb.sv ====
/*
 * Self-checking bench for eps_core with a serial master model.
 * Assumes a shortened write cycle count.
 */
`timescale 1ns/1ps
`default_nettype none

module eps_core_tb;
    import eps_pkg::*;
    localparam int unsigned WCC = 1000;
    logic i_clk = 1'b0;
    logic rst_n = 1'b0;
    logic nv_clr_n = 1'b0;
    logic wp_n = 1'b1;
    logic sck, cs_n, si, so, so_oe, so_line, busy, latch, start;
    logic [10:0] addr;
    int bad_count = 0;
    int total_checks = 0;
    int starts = 0;

    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (start === 1'b1) starts++;
    assign so_line = so_oe ? so : 1'bz;

    eps_core #(.WRITE_CYCLE_COUNT(WCC)) dut (.i_clk(i_clk), .i_rst_n(rst_n),
        .i_nv_clr_n(nv_clr_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n),
        .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_write_latch(latch),
        .o_array_write_start(start), .o_array_addr(addr));
    eps_spi_master m (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so_line));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic send(input logic [31:0] d, input int n);
        logic [31:0] rd;
        m.xfer(d, n, rd);
    endtask
    task automatic status_is(input logic [7:0] exp);
        logic [7:0] v;
        m.read_status(v);
        check("status", {24'h0, v}, {24'h0, exp});
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 5000) begin
            @(posedge i_clk);
            k++;
        end
        check("idle in time", k < 5000, 1);
    endtask
    task automatic arr_write(input logic [10:0] a);
        send({24'h00_0000, OPC_LATCH_SET}, 8);
        send({OPC_ARRAY_WRITE, 5'h00, a, 8'hA5}, 32);
    endtask
    task automatic set_wp(input logic v);
        @(posedge i_clk) wp_n <= v;
        repeat (4) @(posedge i_clk);
    endtask
    task automatic do_reset();
        @(posedge i_clk) rst_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        rst_n <= 1'b1;
        nv_clr_n <= 1'b1;
        repeat (2) @(posedge i_clk);
    endtask

    task automatic t_power();
        check("latch", latch, 0);
        check("oe", so_oe, 0);
        status_is(8'h00);
    endtask
    task automatic t_latch();
        send({24'h00_0000, OPC_LATCH_SET}, 8);
        check("latch", latch, 1);
        status_is(8'h02);
        send({24'h00_0000, OPC_LATCH_CLEAR}, 8);
        check("latch", latch, 0);
        send({24'h00_0000, OPC_LATCH_SET}, 7);
        check("latch", latch, 0);
        send({16'h0000, OPC_STATUS_WRITE, 8'h8C}, 16);
        check("busy", busy, 0);
        send({OPC_ARRAY_WRITE, 16'h0010, 8'hA5}, 32);
        check("starts", starts, 0);
    endtask
    task automatic t_status();
        m.status_write(8'hFF);
        wait_idle();
        status_is(8'h8C);
        check("latch", latch, 0);
    endtask
    task automatic t_hw();
        set_wp(1'b0);
        m.status_write(8'h00);
        check("busy", busy, 0);
        check("latch", latch, 1);
        send({24'h00_0000, OPC_LATCH_CLEAR}, 8);
        check("latch", latch, 0);
        set_wp(1'b1);
        m.status_write(8'h80);
        wait_idle();
        status_is(8'h80);
        set_wp(1'b0);
        arr_write(11'h7F0);
        check("start", starts, 1);
        check("addr", addr, 11'h7F0);
        status_is(8'h83);
        check("addr", addr, 11'h7F0);
        send({24'h00_0000, OPC_LATCH_CLEAR}, 8);
        check("latch", latch, 1);
        wait_idle();
        check("latch", latch, 0);
        set_wp(1'b1);
        m.status_write(8'h0C);
        set_wp(1'b0);
        wait_idle();
        set_wp(1'b1);
        status_is(8'h0C);
    endtask
    task automatic t_block();
        logic [10:0] ad [4] = '{11'h7FF, 11'h5FF, 11'h3FF, 11'h000};
        logic [10:0] a;
        int s, e;
        for (int i = 0; i < 8; i++) begin
            a = (i[0]) ? ad[i / 2] + 11'h001 : ad[i / 2];
            m.status_write({4'h0, i[2:1], 2'b00});
            wait_idle();
            e = (i < 2) ? 1 : (i < 4) ? (a < 11'h600) : (i < 6) ? (a < 11'h400) : 0;
            s = starts;
            arr_write(a);
            check("start", starts - s, e);
            if (e == 1) check("addr", addr, a);
            wait_idle();
        end
        do_reset();
        status_is(8'h0C);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #450_000;
        bad_count++;
        summarize();
    end
    initial begin
        do_reset();
        t_power();
        t_latch();
        t_status();
        t_hw();
        t_block();
        summarize();
    end
endmodule

bind eps_core eps_core_chk #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) u_chk (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .o_so_oe(o_so_oe), .o_busy(o_busy),
    .o_write_latch(o_write_latch), .o_array_write_start(o_array_write_start));

`default_nettype wire

// ==== eps_link.sv ====
/*
 * Serial clock side: samples serial input on rising edges and passes each bit
 * to the core by a toggle; shifts the status byte out after a status read code.
 * Assumes chip select and serial input are timed to the serial clock.
 */
`timescale 1ns/1ps
`default_nettype none

module eps_link
    import eps_pkg::*;
(
    input wire logic i_sck,
    input wire logic i_rst_n,
    input wire logic i_cs_n,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    eps_link_if.link lnk
);

    typedef struct packed {
        logic bit_tgl;
        logic bit_val;
        logic [7:0] st_s1;
        logic [7:0] st_s2;
    } eps_lk_type;

    typedef struct packed {
        logic [3:0] cnt;
        logic [6:0] opc;
        logic rd_on;
        logic [7:0] tx;
    } eps_fr_type;

    eps_lk_type lk_reg, lk_next;
    eps_fr_type fr_reg, fr_next;
    logic link_clr;
    logic so_reg;
    logic oe_reg;

    // Frame state ends with the frame itself
    assign link_clr = i_cs_n | ~i_rst_n;

    always_comb begin
        lk_next = lk_reg;
        lk_next.st_s1 = lnk.status;
        lk_next.st_s2 = lk_reg.st_s1;
        if (!i_cs_n) begin
            lk_next.bit_tgl = ~lk_reg.bit_tgl;
            lk_next.bit_val = i_si;
        end
    end

    always_comb begin
        fr_next = fr_reg;
        if (fr_reg.cnt != 4'h8) begin
            fr_next.cnt = fr_reg.cnt + 4'h1;
            fr_next.opc = {fr_reg.opc[5:0], i_si};
            if (fr_reg.cnt == 4'h7 && {fr_reg.opc, i_si} == OPC_STATUS_READ) begin
                fr_next.rd_on = 1'b1;
                fr_next.tx = lk_reg.st_s2;
            end
        end else if (fr_reg.rd_on) begin
            fr_next.tx = {fr_reg.tx[6:0], fr_reg.tx[7]};
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    always_ff @(posedge i_sck or posedge link_clr) begin
        if (link_clr) begin
            fr_reg <= '0;
        end else begin
            fr_reg <= fr_next;
        end
    end

    // Output changes after the falling edge; released while deselected
    always_ff @(negedge i_sck or posedge link_clr) begin
        if (link_clr) begin
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            so_reg <= fr_reg.tx[7];
            oe_reg <= fr_reg.rd_on;
        end
    end

    assign lnk.bit_tgl = lk_reg.bit_tgl;
    assign lnk.bit_val = lk_reg.bit_val;
    assign o_so = so_reg;
    assign o_so_oe = oe_reg;

endmodule

`default_nettype wire

// ==== eps_link_if.sv ====
/*
 * Carrier between the serial clock side and the core side.
 * Assumes each signal is a flop output in its source domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface eps_link_if;
    logic bit_tgl;
    logic bit_val;
    logic [7:0] status;

    modport core(input bit_tgl, input bit_val, output status);
    modport link(output bit_tgl, output bit_val, input status);
endinterface

`default_nettype wire

// ==== eps_nv_cells.sv ====
/*
 * Nonvolatile status cells: hardware protect enable and the two block protect
 * bits. Untouched by the functional reset; cleared only by the erase input.
 */
`timescale 1ns/1ps
`default_nettype none

module eps_nv_cells
    import eps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nv_clr_n,
    input wire logic i_we,
    input wire logic [2:0] i_wdata,
    output logic o_hw_protect_enable,
    output logic [1:0] o_block_protect
);

    typedef struct packed {
        logic hwpe;
        logic [1:0] bp;
    } eps_nv_type;

    eps_nv_type nv_reg, nv_next;

    always_comb begin
        nv_next = nv_reg;
        if (i_we) begin
            nv_next = i_wdata;
        end
    end

    // Survives power-on reset of the rest of the block
    always_ff @(posedge i_clk or negedge i_nv_clr_n) begin
        if (!i_nv_clr_n) begin
            nv_reg <= NV_CLEAR_VALUE;
        end else begin
            nv_reg <= nv_next;
        end
    end

    assign o_hw_protect_enable = nv_reg.hwpe;
    assign o_block_protect = nv_reg.bp;

endmodule

`default_nettype wire

// ==== eps_pkg.sv ====
/*
 * Shared constants and types for the serial EEPROM protection and status block:
 * command codes, status byte layout, block protect codes, write cycle timing.
 * Assumes a 200 MHz core clock.
 */
`default_nettype none

package eps_pkg;

    // Command codes, shifted most significant bit first
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;
    localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

    // Status byte field positions
    localparam int unsigned SR_BUSY_POS = 0;
    localparam int unsigned SR_LATCH_POS = 1;
    localparam int unsigned SR_BP_LO_POS = 2;
    localparam int unsigned SR_BP_HI_POS = 3;
    localparam int unsigned SR_HWPE_POS = 7;

    // Block protect codes and protected ranges
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [10:0] QUARTER_BASE = 11'h600;
    localparam logic [10:0] HALF_BASE = 11'h400;
    localparam logic [10:0] ARRAY_TOP = 11'h7ff;

    // Frame lengths in bytes
    localparam logic [2:0] LEN_LATCH_CMD = 3'h1;
    localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
    localparam logic [2:0] LEN_ARRAY_WRITE_MIN = 3'h4;

    // Reset values
    localparam logic [2:0] NV_CLEAR_VALUE = 3'h0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Write cycle timing (longest time, rounded down)
    localparam int unsigned WRITE_TIME_NS = 5_000_000;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TIMER_W = 20;

    typedef enum logic [1:0] {
        EPS_IDLE = 2'b00,
        EPS_ARRAY_PROG = 2'b01,
        EPS_STATUS_PROG = 2'b10
    } eps_cycle_type;

    function automatic logic eps_is_protected(input logic [10:0] addr, input logic [1:0] bp);
        logic hit;
        hit = 1'b0;
        case (bp)
            BP_NONE: hit = 1'b0;
            BP_QUARTER: hit = (addr >= QUARTER_BASE) && (addr <= ARRAY_TOP);
            BP_HALF: hit = (addr >= HALF_BASE) && (addr <= ARRAY_TOP);
            BP_ALL: hit = 1'b1;
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

endpackage

`default_nettype wire

// ==== eps_spi_master.sv ====
/*
 * Serial bus master model: mode 0 frames, clock idles low between frames.
 * Assumes the bench reads the data out line as released when not enabled.
 */
`timescale 1ns/1ps
`default_nettype none

module eps_spi_master
    import eps_pkg::*;
(
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
    end

    // Clocks out n bits of d and gathers the data out line
    task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] rd);
        rd = '0;
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_si = d[i];
            #80 o_sck = 1'b1;
            rd = {rd[30:0], i_so};
            #80 o_sck = 1'b0;
        end
        #80 o_cs_n = 1'b1;
        o_si = ~o_si;
        #100;
    endtask

    task automatic read_status(output logic [7:0] v);
        logic [31:0] rd;
        xfer({16'h0000, OPC_STATUS_READ, 8'h00}, 16, rd);
        v = rd[7:0];
    endtask

    // Latch set then status write; data goes only through this frame
    task automatic status_write(input logic [7:0] d);
        logic [31:0] rd;
        xfer({24'h00_0000, OPC_LATCH_SET}, 8, rd);
        xfer({16'h0000, OPC_STATUS_WRITE, d}, 16, rd);
    endtask
endmodule

`default_nettype wire
